/* File: hw/p3c_port3_ctrl.sv */
// The Wishbone slave port was chosen for this implementation.
`timescale 1ns/10ps
`include "p3c_defs.svh"

// Summary of operation
// - Amplifier-select bit replaces the first comparator with the amplifier, whatever analog bit holds.
// - Analog bit clear makes all four low pins plain digital inputs.
// - Analog bit set sends pins 0, 2 and 3 to the comparators.
// - Analog set and amplifier clear also sends pin 1 to a comparator.
// - Analog set and amplifier set sends pin 1 to the amplifier input.
// - Config bit 0 picks port 2 drive: zero open-drain, one push-pull.
// - Stop-mode recovery leaves the config register untouched; only reset clears it.
// - Reading pin data returns input pin levels 3..0 in the low bits.
// - Writing pin data drives output pins 7..4 from the upper bits.
// - Config register decodes at index F7h only, whatever byte offset bits 1..0 hold.
// - Reading output bits returns the last written value, not the pin.
module p3c_port3_ctrl
  import p3c_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        reset_n_in,
  // Wishbone slave
  input  wire logic        wb_cyc_in,
  input  wire logic        wb_stb_in,
  input  wire logic        wb_we_in,
  input  wire logic [11:0] wb_adr_in,
  input  wire logic [3:0]  wb_sel_in,
  input  wire logic [31:0] wb_dat_in,
  output logic      [31:0] wb_dat_out,
  output logic             wb_ack_out,
  // Power management
  input  wire logic        stop_recover_in,
  // Port pins
  input  wire logic [3:0]  in_pins_in,
  output logic      [3:0]  out_pins_out,
  // Analog and drive control
  output logic      [3:0]  digital_en_out,
  output logic      [3:0]  comp_en_out,
  output logic             first_comparator_en_out,
  output logic             amp_en_out,
  output logic             amp_input_sel_out,
  output logic             p2_push_pull_out
);

  // ----------------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------------
  p3c_mode_if mode_if ();

  p3c_mode_t   mode_q;
  p3c_mode_t   mode_d;
  logic [3:0]  out_q;
  logic [3:0]  out_d;
  logic        ack_q;
  logic        ack_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic [3:0]  pins_sync;
  logic        req;
  logic        take;
  logic        hit_data;
  logic        hit_cfg;
  logic        wr_cfg;
  logic        wr_data;
  logic        rd_cfg;
  logic        rd_data;

  // ----------------------------------------------------------------------------
  // Input pin synchroniser
  // ----------------------------------------------------------------------------
  p3c_sync #(
    .WIDTH (4)
  ) u_pin_sync (
    .clk_in     (clk_in),
    .reset_n_in (reset_n_in),
    .async_in   (in_pins_in),
    .sync_out   (pins_sync)
  );

  // ----------------------------------------------------------------------------
  // Pin routing
  // ----------------------------------------------------------------------------
  assign mode_if.mode = mode_q;

  p3c_pin_route u_route (
    .mode_if (mode_if.mux)
  );

  // ----------------------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------------------
  assign req      = wb_cyc_in && wb_stb_in;
  assign take     = req && !ack_q;
  assign hit_data = (wb_adr_in[11:2] == `P3C_PIN_DATA_IDX);
  assign hit_cfg  = (wb_adr_in[11:2] == `P3C_INPUT_CONFIG_IDX);

  // ----------------------------------------------------------------------------
  // Bus strobes
  // ----------------------------------------------------------------------------
  // A write without lane 0 enabled carries no register byte and is dropped.
  assign wr_cfg  = take && wb_we_in && wb_sel_in[0] && hit_cfg;
  assign wr_data = take && wb_we_in && wb_sel_in[0] && hit_data;
  assign rd_cfg  = take && !wb_we_in && hit_cfg;
  assign rd_data = take && !wb_we_in && hit_data;

  // ----------------------------------------------------------------------------
  // Bus handshake
  // ----------------------------------------------------------------------------
  always_comb begin
    ack_d = take;
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= ack_d;
    end
  end

  // ----------------------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------------------
  // Stop-mode recovery is deliberately not an input to this group.
  always_comb begin
    mode_d = mode_q;
    out_d  = out_q;
    if (wr_cfg) begin
      mode_d.p2_push_pull = wb_dat_in[`P3C_CFG_P2_PP_BIT];
      mode_d.analog_sel   = wb_dat_in[`P3C_CFG_ANALOG_BIT];
      mode_d.amp_sel      = wb_dat_in[`P3C_CFG_AMP_BIT];
    end
    if (wr_data) begin
      out_d = wb_dat_in[7:4];
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      mode_q <= p3c_mode_t'(`P3C_CFG_RESET);
      out_q  <= `P3C_OUT_RESET;
    end else begin
      mode_q <= mode_d;
      out_q  <= out_d;
    end
  end

  // ----------------------------------------------------------------------------
  // Register reads
  // ----------------------------------------------------------------------------
  // Unmapped addresses are acknowledged and read as zero.
  always_comb begin
    rdata_d = rdata_q;
    if (take) begin
      rdata_d = 32'h0000_0000;
      if (rd_data) begin
        rdata_d[7:4] = out_q;
        rdata_d[3:0] = pins_sync;
      end
      if (rd_cfg) begin
        rdata_d[7:3] = `P3C_CFG_RSVD_VALUE;
        rdata_d[2:0] = mode_q;
      end
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rdata_q <= 32'h0000_0000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // ----------------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------------
  assign wb_ack_out       = ack_q;
  assign wb_dat_out       = rdata_q;
  assign out_pins_out     = out_q;
  assign p2_push_pull_out = mode_q.p2_push_pull;
  assign amp_en_out       = mode_if.amp_en;

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      digital_en_out[i] = (mode_if.route[i] == P3C_ROUTE_DIGITAL);
      comp_en_out[i]    = (mode_if.route[i] == P3C_ROUTE_COMPARATOR);
    end
    amp_input_sel_out       = (mode_if.route[1] == P3C_ROUTE_AMPLIFIER);
    first_comparator_en_out = comp_en_out[1] && !mode_if.amp_en;
  end

  // ----------------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------------
  ack_timing_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    take |=> wb_ack_out ##1 !wb_ack_out)
    else $error("ack not one cycle after request");

  amp_replace_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    mode_q.amp_sel |-> amp_en_out && !first_comparator_en_out)
    else $error("amplifier does not replace first comparator");

  rsvd_read_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (take && !wb_we_in && hit_cfg) |=> wb_dat_out[7:3] == 5'h1F && wb_dat_out[31:8] == 24'h000000)
    else $error("reserved config bits not read as ones");

  digital_mode_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    !mode_q.analog_sel |-> digital_en_out == 4'hF && comp_en_out == 4'h0 && !amp_input_sel_out)
    else $error("low pins not digital in digital mode");

  comp_pins_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    mode_q.analog_sel |-> comp_en_out[0] && comp_en_out[2] && comp_en_out[3] && digital_en_out == 4'h0)
    else $error("pins 0 2 3 not on comparators");

  pin1_comp_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (mode_q.analog_sel && !mode_q.amp_sel) |-> comp_en_out[1] && first_comparator_en_out)
    else $error("pin 1 not on comparator");

  pin1_amp_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (mode_q.analog_sel && mode_q.amp_sel) |-> amp_input_sel_out && !comp_en_out[1])
    else $error("pin 1 not on amplifier");

  drive_write_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (take && wb_we_in && wb_sel_in[0] && hit_cfg) |=> p2_push_pull_out == $past(wb_dat_in[0]))
    else $error("port 2 drive mode not written");

  stop_keep_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (stop_recover_in && !(take && wb_we_in && hit_cfg)) |=> $stable(mode_q))
    else $error("mode changed on stop recovery");

  pin_read_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (take && !wb_we_in && hit_data) |=> wb_dat_out[3:0] == $past(pins_sync))
    else $error("pin levels not returned");

  out_write_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (take && wb_we_in && wb_sel_in[0] && hit_data) |=> out_pins_out == $past(wb_dat_in[7:4]))
    else $error("output pins not written");

  cfg_decode_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (take && wb_we_in && !hit_cfg) |=> $stable(mode_q))
    else $error("config written at wrong address");

  out_readback_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (take && !wb_we_in && hit_data) |=> wb_dat_out[7:4] == $past(out_q))
    else $error("output bits not read back");

  reset_value_a: assert property (@(posedge clk_in)
    $rose(reset_n_in) |-> mode_q == 3'h0 && out_pins_out == 4'h0 && !wb_ack_out)
    else $error("reset values wrong");

  // The bus checks below hold the register contract; the rest guard pin routing.
  ack_single_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    wb_ack_out |=> !wb_ack_out)
    else $error("ack longer than one cycle");

  ack_idle_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    !req |=> !wb_ack_out)
    else $error("ack without request");

  dat_hold_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    !take |=> $stable(wb_dat_out))
    else $error("read data changed without request");

  dat_upper_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    wb_dat_out[31:8] == 24'h000000)
    else $error("upper read data not zero");

  cfg_readback_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    rd_cfg |=> wb_dat_out[2:0] == $past(mode_q))
    else $error("mode bits not read back");

  sel_drop_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (take && wb_we_in && !wb_sel_in[0]) |=> $stable(mode_q) && $stable(out_pins_out))
    else $error("write without lane 0 took effect");

  out_keep_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    !wr_data |=> $stable(out_pins_out))
    else $error("output pins changed without write");

  mode_write_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    wr_cfg |=> mode_q.analog_sel == $past(wb_dat_in[1]) && mode_q.amp_sel == $past(wb_dat_in[2]))
    else $error("analog or amplifier bit not written");

  mode_keep_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    !wr_cfg |=> $stable(mode_q))
    else $error("mode changed without config write");

  amp_alone_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (!mode_q.analog_sel && mode_q.amp_sel) |-> amp_en_out && digital_en_out[1] && !first_comparator_en_out)
    else $error("amplifier bit alone does not replace first comparator");

  amp_off_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    !mode_q.amp_sel |-> !amp_en_out && !amp_input_sel_out)
    else $error("amplifier active while disabled");

  route_excl_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (digital_en_out & comp_en_out) == 4'h0 && !(amp_input_sel_out && (digital_en_out[1] || comp_en_out[1])))
    else $error("pin routed to two paths");

endmodule

/* File: inc/p3c_defs.svh */
`ifndef P3C_DEFS_SVH
`define P3C_DEFS_SVH

// ----------------------------------------------------------------------------
// Register indices and byte addresses
// ----------------------------------------------------------------------------
`define P3C_PIN_DATA_IDX      10'h003
`define P3C_INPUT_CONFIG_IDX  10'h0F7
`define P3C_PIN_DATA_ADR      12'h00C
`define P3C_INPUT_CONFIG_ADR  12'h3DC

// ----------------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------------
`define P3C_CFG_P2_PP_BIT     0
`define P3C_CFG_ANALOG_BIT    1
`define P3C_CFG_AMP_BIT       2
`define P3C_CFG_RSVD_VALUE    5'h1F
`define P3C_CFG_RESET         3'h0
`define P3C_OUT_RESET         4'h0

// ----------------------------------------------------------------------------
// Timing counts
// ----------------------------------------------------------------------------
`define P3C_SYNC_STAGES       2

`endif

/* File: inc/p3c_pkg.sv */
package p3c_pkg;

  // Mode bits held in the input configuration register.
  typedef struct packed {
    logic amp_sel;
    logic analog_sel;
    logic p2_push_pull;
  } p3c_mode_t;

  // Where one low port pin is routed.
  typedef enum logic [2:0] {
    P3C_ROUTE_DIGITAL    = 3'b001,
    P3C_ROUTE_COMPARATOR = 3'b010,
    P3C_ROUTE_AMPLIFIER  = 3'b100
  } p3c_route_t;

endpackage

/* File: inc/p3c_mode_if.sv */
`timescale 1ns/10ps
interface p3c_mode_if;
  import p3c_pkg::*;
  p3c_mode_t  mode;
  p3c_route_t route [4];
  logic       amp_en;
  modport ctrl (output mode, input route, input amp_en);
  modport mux  (input mode, output route, output amp_en);
endinterface

/* File: hw/p3c_sync.sv */
`timescale 1ns/10ps
module p3c_sync #(
  parameter int WIDTH = 4
) (
  // Clock and reset
  input  wire logic             clk_in,
  input  wire logic             reset_n_in,
  // Data
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;
endmodule

/* File: hw/p3c_pin_route.sv */
`timescale 1ns/10ps
module p3c_pin_route
  import p3c_pkg::*;
(
  // Mode in, routes out
  p3c_mode_if.mux mode_if
);
  // ----------------------------------------------------------------------------
  // Pin routing
  // ----------------------------------------------------------------------------
  always_comb begin
    mode_if.amp_en = mode_if.mode.amp_sel;
    for (int i = 0; i < 4; i++) begin
      if (mode_if.mode.analog_sel) begin
        mode_if.route[i] = P3C_ROUTE_COMPARATOR;
      end else begin
        mode_if.route[i] = P3C_ROUTE_DIGITAL;
      end
    end
    if (mode_if.mode.analog_sel && mode_if.mode.amp_sel) begin
      mode_if.route[1] = P3C_ROUTE_AMPLIFIER;
    end
  end
endmodule

/* File: sim/p3c_port3_ctrl_bench.sv */
`timescale 1ns/10ps
`include "p3c_defs.svh"
module p3c_port3_ctrl_bench;
  // ----------------------------------------------------------------------------
  // Signals and design instance
  // ----------------------------------------------------------------------------
  logic        clk_in, reset_n_in, wb_cyc_in, wb_stb_in, wb_we_in, stop_recover_in;
  logic [11:0] wb_adr_in;
  logic [3:0]  wb_sel_in, in_pins_in, out_pins_out, digital_en_out, comp_en_out;
  logic [31:0] wb_dat_in, wb_dat_out, rd;
  logic        wb_ack_out, first_comparator_en_out, amp_en_out, amp_input_sel_out, p2_push_pull_out;
  logic [12:0] mode_seen;
  int          err_total, checks_done, cfg_m, out_m, d, p, rv;

  assign mode_seen = {digital_en_out, comp_en_out, first_comparator_en_out, amp_en_out,
                      amp_input_sel_out, p2_push_pull_out};

  p3c_port3_ctrl i_dut (.clk_in(clk_in), .reset_n_in(reset_n_in), .wb_cyc_in(wb_cyc_in),
    .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in), .wb_sel_in(wb_sel_in),
    .wb_dat_in(wb_dat_in), .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out),
    .stop_recover_in(stop_recover_in), .in_pins_in(in_pins_in), .out_pins_out(out_pins_out),
    .digital_en_out(digital_en_out), .comp_en_out(comp_en_out),
    .first_comparator_en_out(first_comparator_en_out), .amp_en_out(amp_en_out),
    .amp_input_sel_out(amp_input_sel_out), .p2_push_pull_out(p2_push_pull_out));

  // ----------------------------------------------------------------------------
  // Model, bus tasks and comparison
  // ----------------------------------------------------------------------------
  // Expected pin routing for a mode value, in the order of mode_seen.
  function automatic logic [12:0] mode_exp(input int m);
    return {m[1] ? 4'h0 : 4'hF, m[1] ? (m[2] ? 4'hD : 4'hF) : 4'h0,
            m[1] & ~m[2], m[2], m[1] & m[2], m[0]};
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wb_xfer(input logic we, input logic [11:0] adr, input logic [3:0] sel,
                         input logic [31:0] dat);
    int n;
    @(posedge clk_in);
    wb_cyc_in <= 1'b1;
    wb_stb_in <= 1'b1;
    wb_we_in  <= we;
    wb_adr_in <= adr;
    wb_sel_in <= sel;
    wb_dat_in <= dat;
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (wb_ack_out !== 1'b1 && n < 50);
    if (n >= 50) err_total++;
    rd = wb_dat_out;
    wb_cyc_in <= 1'b0;
    wb_stb_in <= 1'b0;
    wb_we_in  <= 1'b0;
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d, mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------------------
  // Clock, watchdog and tests
  // ----------------------------------------------------------------------------
  initial begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end

  initial begin
    #(20000 * 50);
    err_total++;
    tally_and_finish();
  end

  initial begin
    {reset_n_in, wb_cyc_in, wb_stb_in, wb_we_in, stop_recover_in} = '0;
    {wb_adr_in, wb_sel_in, wb_dat_in, in_pins_in} = '0;
    err_total = 0;
    checks_done = 0;
    rv = $urandom(66978);
    repeat (3) @(posedge clk_in);
    reset_n_in <= 1'b1;
    @(posedge clk_in);
    check(32'(mode_seen), 32'(mode_exp(0)));
    check(32'(out_pins_out), 32'h0);
    wb_xfer(1'b0, `P3C_INPUT_CONFIG_ADR, 4'hF, 32'h0);
    check(rd, 32'hF8);
    wb_xfer(1'b0, `P3C_PIN_DATA_ADR, 4'hF, 32'h0);
    check(rd & 32'hF0, 32'h0);
    $display("reset test done");
    for (int m = 0; m < 8; m++) begin
      wb_xfer(1'b1, `P3C_INPUT_CONFIG_ADR | 12'($urandom % 4), 4'hF, {24'($urandom), 5'h1F, 3'(m)});
      cfg_m = m;
      check(32'(mode_seen), 32'(mode_exp(cfg_m)));
      wb_xfer(1'b0, `P3C_INPUT_CONFIG_ADR, 4'hF, 32'h0);
      check(rd, 32'(8'hF8 | cfg_m));
    end
    $display("mode test done");
    for (int i = 0; i < 16; i++) begin
      d = $urandom % 256;
      p = $urandom % 16;
      in_pins_in <= 4'(p);
      wb_xfer(1'b1, `P3C_PIN_DATA_ADR, 4'hF, 32'(d));
      out_m = d / 16;
      check(32'(out_pins_out), 32'(out_m));
      repeat (3) @(posedge clk_in);
      wb_xfer(1'b0, `P3C_PIN_DATA_ADR, 4'hF, 32'h0);
      check(rd, 32'(out_m * 16 + p));
    end
    wb_xfer(1'b1, `P3C_PIN_DATA_ADR, 4'hE, 32'(~out_m * 16));
    check(32'(out_pins_out), 32'(out_m));
    wb_xfer(1'b1, 12'h010, 4'hF, 32'hFF);
    wb_xfer(1'b0, 12'h010, 4'hF, 32'h0);
    check(rd, 32'h0);
    check(32'(mode_seen), 32'(mode_exp(cfg_m)));
    check(32'(out_pins_out), 32'(out_m));
    $display("data test done");
    stop_recover_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    stop_recover_in <= 1'b0;
    @(posedge clk_in);
    check(32'(mode_seen), 32'(mode_exp(cfg_m)));
    wb_xfer(1'b0, `P3C_INPUT_CONFIG_ADR, 4'hF, 32'h0);
    check(rd, 32'(8'hF8 | cfg_m));
    check(32'(out_pins_out), 32'(out_m));
    $display("stop recovery test done");
    @(posedge clk_in);
    reset_n_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    reset_n_in <= 1'b1;
    @(posedge clk_in);
    check(32'(mode_seen), 32'(mode_exp(0)));
    check(32'(out_pins_out), 32'h0);
    wb_xfer(1'b0, `P3C_INPUT_CONFIG_ADR, 4'hF, 32'h0);
    check(rd, 32'hF8);
    $display("second reset test done");
    tally_and_finish();
  end
endmodule
